/* File: fwsr_flash_model.sv */
// Behavioural flash device that answers the host's status reads.
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input wire logic arm, // Rising edge loads a new operation.
  input wire logic [1:0] op, // 0 array, 1 program, 2 erase, 3 failing.
  input wire logic [7:0] value, // Programmed byte or erased contents.
  input wire logic [7:0] busy_reads, // Status reads before completion.
  input wire logic timer_done, // Erase acceptance window is over.
  input wire fwsr_flash_out_type pins, // Host strobes, address and data.
  output logic [7:0] rdata, // Data pins as seen by the host.
  output logic [18:0] read_addr // Address of the latest read.
);
  logic [1:0] state = 2'h0;
  logic [7:0] left = 8'h00;
  logic tog = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  always @(posedge arm) begin
    state = op;
    left = busy_reads;
  end
  // Each read start advances the toggle bits and the countdown.
  always @(negedge pins.out_en_n) begin
    if (!pins.chip_en_n) begin
      read_addr = pins.addr;
      tog = ~tog;
      if (state != 2'h3 && left == 8'h00) begin
        state = 2'h0;
      end else if (left != 8'h00) begin
        left = left - 8'h01;
      end
    end
  end
  always @(posedge pins.out_en_n) begin
    last = val;
  end
  always @(posedge pins.write_en_n) begin
    if (pins.data_oe && pins.data_out == RESET_CMD) begin
      state = 2'h0;
    end
  end
  always_comb begin
    case (state)
      2'h1: val = {~value[7], tog, 6'h00};
      2'h2: val = {1'b0, tog, 2'b00, timer_done, tog, 2'b00};
      2'h3: val = {~value[7], tog, 1'b1, 5'h00};
      default: val = value;
    endcase
  end
  // Released pins show the inverse of the last byte, never a held value.
  assign rdata = (!pins.chip_en_n && !pins.out_en_n) ? val : ~last;
endmodule
`default_nettype wire

/* File: fwsr_host.sv */
// Host controller that runs the flash polling, toggle and timer checks.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fwsr_host
  import fwsr_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  output fwsr_flash_out_type flash_out, // Flash strobes, address and data drive.
  input wire logic [7:0] flash_data_in // Flash data pins as read.
);

  typedef enum logic [2:0] {
    IDLE, READ_LOW, READ_TAKE, WRITE_LOW, WRITE_HOLD, EVAL
  } fwsr_state_type;

  fwsr_state_type state, next_state;
  fwsr_mode_type mode, next_mode;
  logic [18:0] addr, next_addr;
  logic [7:0] data, next_data;
  logic [7:0] last, next_last;
  logic [1:0] reads, next_reads;
  logic busy, next_busy;
  logic done, next_done;
  logic fail, next_fail;
  logic timer, next_timer;
  logic susp, next_susp;
  logic confirm, next_confirm;
  logic [1:0] moved, next_moved;
  logic limit_seen, next_limit_seen;
  logic [COUNT_WIDTH-1:0] count, next_count;
  fwsr_flash_out_type next_flash_out;
  logic [7:0] sync1, sync2;

  // Flash data passes two flip-flops before any logic reads it.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= flash_data_in;
      sync2 <= sync1;
    end
  end

  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input int pos);
    toggled = a[pos] ^ b[pos];
  endfunction

  wire logic apb_write = psel && penable && pwrite;
  wire logic start = apb_write && (paddr == REG_CTRL) && pwdata[CTRL_START] && !busy;
  // Toggle movement is judged between this read and the one before it, never within one read.
  wire logic any_toggle = |moved;

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_addr = addr;
    next_data = data;
    next_last = last;
    next_reads = reads;
    next_busy = busy;
    next_done = done;
    next_fail = fail;
    next_timer = timer;
    next_susp = susp;
    next_count = count;
    next_flash_out = flash_out;
    next_confirm = confirm;
    next_moved = moved;
    next_limit_seen = limit_seen;
    if (apb_write && !busy && paddr == REG_ADDR) begin
      next_addr = pwdata[18:0];
    end
    if (apb_write && !busy && paddr == REG_DATA) begin
      next_data = pwdata[7:0];
    end
    unique case (state)
      IDLE: begin
        if (start) begin
          next_mode = fwsr_mode_type'(pwdata[CTRL_MODE_LSB +: CTRL_MODE_WIDTH]);
          next_busy = 1'b1;
          next_done = 1'b0;
          next_fail = 1'b0;
          next_reads = 2'd0;
          next_confirm = 1'b0;
          next_susp = 1'b0;
          next_count = COUNT_WIDTH'(WRITE_CYCLES);
          next_flash_out.addr = addr;
          next_flash_out.chip_en_n = 1'b0;
          if (fwsr_mode_type'(pwdata[CTRL_MODE_LSB +: CTRL_MODE_WIDTH]) == MODE_RESET) begin
            next_flash_out.write_en_n = 1'b0;
            next_flash_out.data_out = RESET_CMD;
            next_flash_out.data_oe = 1'b1;
            next_state = WRITE_LOW;
          end else begin
            next_flash_out.out_en_n = 1'b0;
            next_count = COUNT_WIDTH'(READ_CYCLES);
            next_state = READ_LOW;
          end
        end
      end
      WRITE_LOW: begin
        next_count = count - 1'b1;
        if (count == '0) begin
          next_flash_out.write_en_n = 1'b1;
          next_state = WRITE_HOLD;
        end
      end
      // The byte is latched on the rising write strobe, so data and select stay one more cycle.
      WRITE_HOLD: begin
        next_flash_out.chip_en_n = 1'b1;
        next_flash_out.data_oe = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = IDLE;
      end
      READ_LOW: begin
        next_count = count - 1'b1;
        if (count == '0) begin
          next_flash_out.out_en_n = 1'b1;
          next_flash_out.chip_en_n = 1'b1;
          next_state = READ_TAKE;
        end
      end
      READ_TAKE: begin
        next_moved = {toggled(sync2, last, DEV_TOGGLE_BIT), toggled(sync2, last, SECT_TOGGLE_BIT)};
        next_limit_seen = last[LIMIT_BIT];
        next_last = sync2;
        next_reads = (reads == 2'd3) ? reads : reads + 2'd1;
        next_state = EVAL;
      end
      EVAL: begin
        next_state = READ_LOW;
        next_count = COUNT_WIDTH'(READ_CYCLES);
        next_flash_out.out_en_n = 1'b0;
        next_flash_out.chip_en_n = 1'b0;
        unique case (mode)
          MODE_POLL: begin
            if (last[POLL_BIT] == data[POLL_BIT] && reads >= 2'd2) begin
              // The read on which the polling bit flips may carry stale low bits, so one more is taken.
              if (confirm) begin
                next_done = 1'b1;
              end else begin
                next_confirm = 1'b1;
              end
            end else if (limit_seen && reads >= 2'd2) begin
              next_fail = 1'b1;
            end
            next_susp = 1'b0;
          end
          MODE_TOGGLE: begin
            // A still device bit with a moving sector bit marks a suspended erase; checking goes on.
            next_susp = (reads >= 2'd2) && !moved[1] && moved[0];
            if (reads >= 2'd2 && !any_toggle) begin
              next_done = 1'b1;
            end else if (reads >= 2'd3 && limit_seen) begin
              next_fail = 1'b1;
            end
          end
          MODE_TIMER: begin
            next_timer = last[TIMER_BIT];
            next_done = 1'b1;
          end
          MODE_RESET: begin
            next_done = 1'b1;
          end
        endcase
        if (next_done || next_fail) begin
          next_busy = 1'b0;
          next_flash_out.out_en_n = 1'b1;
          next_flash_out.chip_en_n = 1'b1;
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= IDLE;
      mode <= MODE_POLL;
      addr <= '0;
      data <= 8'h00;
      last <= 8'h00;
      reads <= 2'd0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      timer <= 1'b0;
      susp <= 1'b0;
      confirm <= 1'b0;
      moved <= 2'b00;
      limit_seen <= 1'b0;
      count <= '0;
      flash_out <= '{chip_en_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1, addr: '0, data_out: 8'h00, data_oe: 1'b0};
    end else begin
      state <= next_state;
      mode <= next_mode;
      addr <= next_addr;
      data <= next_data;
      last <= next_last;
      reads <= next_reads;
      busy <= next_busy;
      done <= next_done;
      fail <= next_fail;
      timer <= next_timer;
      susp <= next_susp;
      confirm <= next_confirm;
      moved <= next_moved;
      limit_seen <= next_limit_seen;
      count <= next_count;
      flash_out <= next_flash_out;
    end
  end

  // Zero-wait APB slave; reads are combinational from registers.
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != REG_CTRL) && (paddr != REG_ADDR)
    && (paddr != REG_DATA) && (paddr != REG_STATUS);
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL: prdata[CTRL_MODE_LSB +: CTRL_MODE_WIDTH] = mode;
      REG_ADDR: prdata[18:0] = addr;
      REG_DATA: prdata[7:0] = data;
      REG_STATUS: begin
        prdata[ST_BUSY] = busy;
        prdata[ST_DONE] = done;
        prdata[ST_FAIL] = fail;
        prdata[ST_TIMER] = timer;
        prdata[ST_SUSP] = susp;
        prdata[ST_DATA_LSB +: 8] = last;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Strobes never overlap, and read data bus is released while reading.
  strobe_excl_a: assert property (@(posedge clock) disable iff (!reset_n)
    !(!flash_out.out_en_n && !flash_out.write_en_n)) else $error("read and write strobes both low");
  reset_byte_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flash_out.write_en_n |-> flash_out.data_out == RESET_CMD && flash_out.data_oe)
    else $error("write strobe without reset byte");
  double_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(done) && mode == MODE_TOGGLE |-> reads >= 2'd2) else $error("toggle done before two reads");
  fail_recheck_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(fail) && mode == MODE_TOGGLE |-> reads == 2'd3) else $error("toggle fail without recheck");
  poll_addr_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flash_out.out_en_n |-> flash_out.addr == addr) else $error("poll read at wrong address");
  read_len_a: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(flash_out.out_en_n) |-> !flash_out.out_en_n [*8]) else $error("read pulse too short");
  busy_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(fail) |-> !busy && flash_out.chip_en_n) else $error("fail left bus active");
  timer_take_a: assert property (@(posedge clock) disable iff (!reset_n)
    state == EVAL && mode == MODE_TIMER |=> timer == $past(last[TIMER_BIT])) else $error("timer bit not taken");
  poll_confirm_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(done) && mode == MODE_POLL |-> confirm) else $error("poll done without a confirming read");
  write_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(flash_out.write_en_n) |-> flash_out.data_oe && !flash_out.chip_en_n)
    else $error("command byte released with the write strobe");
  cover_poll_c: cover property (@(posedge clock) $rose(done) && mode == MODE_POLL);
  cover_toggle_c: cover property (@(posedge clock) $rose(done) && mode == MODE_TOGGLE);
  cover_fail_c: cover property (@(posedge clock) $rose(fail));
  cover_reset_c: cover property (@(posedge clock) !flash_out.write_en_n);

endmodule
`default_nettype wire

/* File: fwsr_pkg.sv */
// Package for the flash write-status host controller.
package fwsr_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_WIDTH = 2;

  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_TIMER = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_DATA_LSB = 8;

  // Flash data bit positions of the status bits.
  localparam int POLL_BIT = 7;
  localparam int DEV_TOGGLE_BIT = 6;
  localparam int LIMIT_BIT = 5;
  localparam int TIMER_BIT = 3;
  localparam int SECT_TOGGLE_BIT = 2;

  // Reset command byte.
  localparam logic [7:0] RESET_CMD = 8'hF0;

  // Flash bus cycle timing, in nanoseconds and clock cycles at 4 ns.
  localparam int CLOCK_NS = 4;
  localparam int READ_CYCLE_NS = 150;
  localparam int READ_CYCLES = (READ_CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WRITE_PULSE_NS = 60;
  localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int COUNT_WIDTH = 8;

  typedef enum logic [1:0] {
    MODE_POLL = 2'h0,
    MODE_TOGGLE = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_RESET = 2'h3
  } fwsr_mode_type;

  typedef struct packed {
    logic chip_en_n;
    logic out_en_n;
    logic write_en_n;
    logic [18:0] addr;
    logic [7:0] data_out;
    logic data_oe;
  } fwsr_flash_out_type;

endpackage

/* File: tb.sv */
// Randomised self-checking bench for the flash status host controller.
`timescale 1ns/1ps
`default_nettype none
module tb
  import fwsr_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fwsr_flash_out_type flash_out;
  logic [7:0] flash_data_in;
  logic arm = 1'b0;
  logic [1:0] op = 2'h0;
  logic [7:0] value = 8'h00;
  logic [7:0] busy_reads = 8'h00;
  logic timer_done = 1'b0;
  logic [18:0] read_addr;
  logic [31:0] seed = 32'h0001_1982;
  int errors = 0;
  int comparisons = 0;
  fwsr_host uut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_out(flash_out), .flash_data_in(flash_data_in));
  fwsr_flash_model flash (.arm(arm), .op(op), .value(value), .busy_reads(busy_reads),
    .timer_done(timer_done), .pins(flash_out), .rdata(flash_data_in), .read_addr(read_addr));
  initial begin
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Returns the status mask in the upper word and the expected bits in the lower.
  function automatic logic [63:0] expect_status(input fwsr_mode_type m, input logic [1:0] o,
    input logic [7:0] v, input logic t);
    if (m == MODE_TIMER) return {32'h0000_001B, 28'h000_0000, t, 3'h2};
    if (m == MODE_RESET) return {32'h0000_0017, 32'h0000_0002};
    if (o == 2'h3) return {32'h0000_0015, 32'h0000_0004};
    return {32'h0000_FF17, 16'h0000, v, 8'h02};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input fwsr_mode_type m, input logic [1:0] o, input logic [7:0] v, input logic [7:0] n,
    input logic t);
    logic [31:0] q;
    logic e;
    logic [18:0] a;
    logic [63:0] x;
    int k;
    q = rnd();
    a = q[18:0];
    x = expect_status(m, o, v, t);
    op <= o;
    value <= v;
    busy_reads <= n;
    timer_done <= t;
    arm <= 1'b1;
    apb(1'b1, REG_ADDR, {13'h0000, a}, q, e);
    arm <= 1'b0;
    apb(1'b1, REG_DATA, {24'h00_0000, v}, q, e);
    apb(1'b1, REG_CTRL, {29'h0, m, 1'b1}, q, e);
    apb(1'b1, REG_ADDR, {13'h0000, ~a}, q, e);
    q = 32'h0000_0001;
    for (k = 0; k < 500 && q[ST_BUSY] !== 1'b0; k++) apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    check(q & x[63:32], x[31:0]);
    if (m != MODE_RESET) check({13'h0000, read_addr}, {13'h0000, a});
    if (m == MODE_RESET) check({30'h0000_0000, flash.state}, 32'h0000_0000);
    apb(1'b0, REG_ADDR, 32'h0000_0000, q, e);
    check(q, {13'h0000, a});
  endtask
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic [31:0] r;
    int i;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
    check(q, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, q, e);
    check({31'h0, e}, 32'h0000_0001);
    run(MODE_POLL, 2'h1, 8'h00, 8'h02, 1'b0);
    run(MODE_TOGGLE, 2'h2, 8'hFF, 8'h02, 1'b0);
    run(MODE_TIMER, 2'h2, 8'hFF, 8'h04, 1'b0);
    run(MODE_TIMER, 2'h2, 8'hFF, 8'h04, 1'b1);
    run(MODE_POLL, 2'h3, 8'h7F, 8'h04, 1'b0);
    run(MODE_RESET, 2'h3, 8'h7F, 8'h00, 1'b0);
    run(MODE_POLL, 2'h0, 8'h5A, 8'h00, 1'b0);
    run(MODE_TOGGLE, 2'h3, 8'h80, 8'h04, 1'b0);
    run(MODE_RESET, 2'h3, 8'h80, 8'h00, 1'b0);
    run(MODE_TOGGLE, 2'h0, 8'hC3, 8'h00, 1'b0);
    for (i = 0; i < 16; i++) begin
      r = rnd();
      run(r[0] ? MODE_TOGGLE : MODE_POLL, r[1] ? 2'h2 : 2'h1, r[1] ? 8'hFF : r[15:8],
        8'h02 + {5'h00, r[4:2]}, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
